// ==== design/arc_pkg.sv ====
// Package of constants and types for the auto-reclose sequencer
package arc_pkg;

    // Clock and millisecond tick
    localparam int unsigned CLK_FREQ_HZ   = 20_000_000;
    localparam int unsigned TICK_TIME_US  = 1000;
    localparam int unsigned TICK_CYC_DEF  = CLK_FREQ_HZ / 1_000_000 * TICK_TIME_US;

    // Synchroniser depth is fixed at three flops plus the agreed output
    localparam int unsigned IN_W      = 10;
    localparam int unsigned IN_PST    = 0;  // Protection start
    localparam int unsigned IN_TRIP   = 1;  // Trip start
    localparam int unsigned IN_POPEN  = 2;  // Breaker pole open
    localparam int unsigned IN_RDY    = 3;  // Breaker ready
    localparam int unsigned IN_BLK    = 4;  // Block
    localparam int unsigned IN_GBLK   = 5;  // Device-wide block
    localparam int unsigned IN_MAN    = 6;  // Manual close
    localparam int unsigned IN_DTDEL  = 7;  // Dead-time delay
    localparam int unsigned IN_3PH    = 8;  // Three-phase trip
    localparam int unsigned IN_RDT    = 9;  // Reduced dead time

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_STAT  = 8'h04;
    localparam logic [7:0] ADDR_SET0  = 8'h40;
    localparam logic [7:0] ADDR_SETN  = 8'h7c;

    // Control word fields
    localparam int unsigned CTRL_EN_BIT    = 0;
    localparam int unsigned CTRL_SRC_BIT   = 1;
    localparam int unsigned CTRL_SHOTS_LSB = 2;
    localparam logic        CTRL_EN_RST    = 1'b0;
    localparam logic        CTRL_SRC_RST   = 1'b0;
    localparam logic [2:0]  CTRL_SHOTS_RST = 3'h1;
    localparam logic [2:0]  SHOTS_MAX      = 3'h4;

    // Status word fields
    localparam int unsigned ST_RUN_BIT   = 0;
    localparam int unsigned ST_CLOSE_BIT = 1;
    localparam int unsigned ST_DYN_BIT   = 2;
    localparam int unsigned ST_MBLK_BIT  = 3;
    localparam int unsigned ST_SHOT_LSB  = 4;
    localparam int unsigned ST_TP_BIT    = 6;
    localparam int unsigned ST_STATE_LSB = 8;

    // Timer settings in milliseconds, one word each from ADDR_SET0
    localparam int unsigned NSET = 16;
    localparam logic [3:0]  IDX_ACT    = 4'h0;
    localparam logic [3:0]  IDX_MAXST  = 4'h1;
    localparam logic [3:0]  IDX_RECL   = 4'h2;
    localparam logic [3:0]  IDX_CBW    = 4'h3;
    localparam logic [3:0]  IDX_DYN    = 4'h4;
    localparam logic [3:0]  IDX_CLOSE  = 4'h5;
    localparam logic [3:0]  IDX_DTDEL  = 4'h6;
    localparam logic [3:0]  IDX_MANBLK = 4'h7;
    localparam logic [3:0]  IDX_DT1    = 4'h8;
    localparam logic [3:0]  IDX_DT3    = 4'hc;
    localparam logic [15:0] SET_RST    = 16'h0064;

    typedef enum logic [3:0] {
        ARC_IDLE, ARC_ACTION, ARC_TRIPPED, ARC_DTDELAY, ARC_DEAD,
        ARC_CBWAIT, ARC_CLOSE, ARC_RECLAIM, ARC_DYNBLK
    } arc_state_t;

endpackage : arc_pkg

// ==== design/arc_seq.sv ====
// Auto-reclose sequencer with Avalon-MM settings and status
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RQ1: At most four shots, dead time then close
// RQ2: Per-shot dead time, single and multi phase
// RQ3: Dead time starts on trip reset or open
// RQ4: Start launches action timer, expiry blocks dynamically
// RQ5: Trip sets in-progress, launches start max timer
// RQ6: Trip-reset mode: trip too long blocks
// RQ7: Open mode: no open before timeout blocks
// RQ8: External logic flags any open pole
// RQ9: Delay input postpones dead time, limited
// RQ10: Dead time end: close pulse plus reclaim
// RQ11: Pickup during reclaim moves to next shot
// RQ12: Reclaim expiry resets to first shot
// RQ13: Wait breaker ready, timeout blocks then resets
// RQ14: Close pulse timed, cut by trip
// RQ15: Manual close disables for set time
// RQ16: Shot count selects zero to four shots
// RQ17: Operation off prevents any sequence
// RQ18: Block or general block disables function
// RQ19: Eight dead times indexed by shot, type
// RQ20: Three-phase once means three-phase thereafter
// RQ21: Reduced dead time input ends dead time
// RQ22: Three-phase trip selects three-phase cycles
// RQ23: Millisecond timers; blocked state drops outputs
module arc_seq import arc_pkg::*; #(
    parameter int unsigned TICK_CYCLES = TICK_CYC_DEF
) (
    input  wire logic        clk_sys,               // System clock, 20 MHz
    input  wire logic        reset_n,               // Async reset, active low
    input  wire logic [7:0]  avs_address,           // Byte address
    input  wire logic        avs_read,              // Read request
    input  wire logic        avs_write,             // Write request
    input  wire logic [31:0] avs_writedata,         // Write data
    input  wire logic [3:0]  avs_byteenable,        // Write byte lanes
    output logic      [31:0] avs_readdata,          // Read data, registered
    output logic             avs_waitrequest,       // Stall until answer ready
    input  wire logic        protection_start_in,   // Protection pickup
    input  wire logic        trip_start_in,         // Protection trip
    input  wire logic        breaker_pole_open_in,  // Any pole open
    input  wire logic        breaker_ready_in,      // Breaker can close
    input  wire logic        block_in,              // Function block
    input  wire logic        general_block_in,      // Device-wide block
    input  wire logic        manual_close_in,       // Manual close given
    input  wire logic        dead_time_delay_in,    // Hold off dead time
    input  wire logic        three_phase_trip_in,   // Trip was three-phase
    input  wire logic        reduced_dead_time_in,  // End dead time now
    output logic             in_progress_out,       // Sequence running
    output logic             close_out              // Close command pulse
);
    typedef struct packed {
        arc_state_t             st;
        logic [15:0]            cnt;    // Phase timer, ms
        logic [15:0]            rcnt;   // Reclaim timer, ms
        logic [15:0]            mcnt;   // Manual-close block timer, ms
        logic                   mblk;
        logic [1:0]             shot;
        logic                   tp;     // Three-phase settings in use
        logic                   en;
        logic                   src;    // 1: breaker open starts dead time
        logic [2:0]             shots;
        logic [NSET-1:0][15:0]  set;
        logic                   ack;
        logic [31:0]            rdata;
        logic                   pst_prev;
    } arc_regs_t;

    arc_regs_t       r, n;
    logic            tick;
    logic [IN_W-1:0] raw_in, syn;
    logic            pst_s, trip_s, popen_s, rdy_s, man_s, dtdel_s, tph_s, rdt_s;
    logic            inhibit, pick, last_shot;
    logic [2:0]      shots_en;
    logic [3:0]      dt_idx;
    logic [4:0]      rd_hit, wr_hit;
    logic [31:0]     wmask, stat_word, ctrl_word, wr_word;

    // Decode a settings address into {hit, index}
    function automatic logic [4:0] set_slot(input logic [7:0] a);
        logic [7:0] off;
        off = a - ADDR_SET0;
        set_slot = {(a >= ADDR_SET0) && (a <= ADDR_SETN) && (a[1:0] == 2'b00), off[5:2]};
    endfunction : set_slot

    arc_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .tick   (tick)
    );

    // External inputs come from other hardware, so all are synchronised
    assign raw_in = {reduced_dead_time_in, three_phase_trip_in, dead_time_delay_in, manual_close_in,
                     general_block_in, block_in, breaker_ready_in, breaker_pole_open_in,
                     trip_start_in, protection_start_in};

    arc_sync #(
        .W(IN_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din    (raw_in),
        .dout   (syn)
    );

    // Named views of the synchronised inputs
    assign pst_s   = syn[IN_PST];
    assign trip_s  = syn[IN_TRIP];
    assign popen_s = syn[IN_POPEN];
    assign rdy_s   = syn[IN_RDY];
    assign man_s   = syn[IN_MAN];
    assign dtdel_s = syn[IN_DTDEL];
    assign tph_s   = syn[IN_3PH];
    assign rdt_s   = syn[IN_RDT];

    // Settings above four shots are clamped rather than rejected
    assign shots_en  = (r.shots > SHOTS_MAX) ? SHOTS_MAX : r.shots; // RQ16
    assign inhibit   = !r.en || syn[IN_BLK] || syn[IN_GBLK] || r.mblk || (shots_en == 3'h0); // RQ17 RQ18
    assign pick      = pst_s || trip_s;
    assign last_shot = ({1'b0, r.shot} + 3'h1) >= shots_en; // RQ1
    assign dt_idx    = (r.tp ? IDX_DT3 : IDX_DT1) + {2'b00, r.shot}; // RQ2 RQ19

    // Register views for the bus
    assign ctrl_word = {27'h0, r.shots, r.src, r.en};
    always_comb begin
        stat_word = '0;
        stat_word[ST_RUN_BIT]                 = in_progress_out;
        stat_word[ST_CLOSE_BIT]               = close_out;
        stat_word[ST_DYN_BIT]                 = (r.st == ARC_DYNBLK);
        stat_word[ST_MBLK_BIT]                = r.mblk;
        stat_word[ST_SHOT_LSB +: 2]           = r.shot;
        stat_word[ST_TP_BIT]                  = r.tp;
        stat_word[ST_STATE_LSB +: 4]          = r.st;
    end

    // Byte-lane mask and merged write words
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
        end
    end
    assign rd_hit  = set_slot(avs_address);
    assign wr_hit  = set_slot(avs_address);
    assign wr_word = (ctrl_word & ~wmask) | (avs_writedata & wmask);

    // Next-state logic for bus, timers and sequence
    always_comb begin
        n = r;
        n.pst_prev = pst_s;
        // One wait cycle per access keeps read data registered
        n.ack = (avs_read || avs_write) && !r.ack;
        if (avs_read && !r.ack) begin
            if (avs_address == ADDR_CTRL) begin
                n.rdata = ctrl_word;
            end else if (avs_address == ADDR_STAT) begin
                n.rdata = stat_word;
            end else if (rd_hit[4]) begin
                n.rdata = {16'h0, r.set[rd_hit[3:0]]};
            end else begin
                n.rdata = '0;
            end
        end
        if (avs_write && r.ack) begin
            if (avs_address == ADDR_CTRL) begin
                n.en    = wr_word[CTRL_EN_BIT];
                n.src   = wr_word[CTRL_SRC_BIT];
                n.shots = wr_word[CTRL_SHOTS_LSB +: 3];
            end else if (wr_hit[4]) begin
                n.set[wr_hit[3:0]] = (r.set[wr_hit[3:0]] & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
            end
        end

        // All timers advance on the shared millisecond tick and saturate
        if (tick && r.cnt != 16'hffff) n.cnt = r.cnt + 16'h1; // RQ23
        if (tick && r.rcnt != 16'hffff) n.rcnt = r.rcnt + 16'h1;
        if (tick && r.mcnt != 16'hffff) n.mcnt = r.mcnt + 16'h1;

        // Manual close holds the function off until its timer runs out
        if (man_s) begin
            n.mblk = 1'b1; // RQ15
            n.mcnt = '0;
        end else if (r.mblk && r.mcnt >= r.set[IDX_MANBLK]) begin
            n.mblk = 1'b0; // RQ15
        end

        if (man_s && r.st != ARC_IDLE && r.st != ARC_DYNBLK) begin
            n.st  = ARC_DYNBLK;
            n.cnt = '0;
        end else if (inhibit && r.st != ARC_IDLE && r.st != ARC_DYNBLK) begin
            n.st   = ARC_IDLE; // RQ18
            n.shot = '0;
            n.tp   = 1'b0;
        end else begin
            unique case (r.st)
                ARC_IDLE: begin
                    n.shot = '0;
                    n.tp   = 1'b0;
                    if (!inhibit && trip_s) begin
                        n.st  = ARC_TRIPPED; // RQ5
                        n.cnt = '0;
                    end else if (!inhibit && pst_s && !r.pst_prev) begin
                        n.st  = ARC_ACTION; // RQ4
                        n.cnt = '0;
                    end
                end
                ARC_ACTION: begin
                    if (trip_s) begin
                        n.st  = ARC_TRIPPED; // RQ5
                        n.cnt = '0;
                    end else if (r.cnt >= r.set[IDX_ACT]) begin
                        n.st  = ARC_DYNBLK; // RQ4
                        n.cnt = '0;
                    end
                end
                ARC_TRIPPED: begin
                    n.tp = r.tp || tph_s; // RQ20 RQ22
                    if (r.src ? popen_s : !trip_s) begin
                        n.st  = ARC_DTDELAY; // RQ3
                        n.cnt = '0;
                    end else if (r.cnt >= r.set[IDX_MAXST]) begin
                        n.st  = ARC_DYNBLK; // RQ6 RQ7
                        n.cnt = '0;
                    end
                end
                ARC_DTDELAY: begin
                    // A delay input stuck high cannot hold the sequence forever
                    if (!dtdel_s || r.cnt >= r.set[IDX_DTDEL]) begin
                        n.st  = ARC_DEAD; // RQ9
                        n.cnt = '0;
                    end
                end
                ARC_DEAD: begin
                    if (rdt_s || r.cnt >= r.set[dt_idx]) begin
                        n.st  = ARC_CBWAIT; // RQ21 RQ2
                        n.cnt = '0;
                    end
                end
                ARC_CBWAIT: begin
                    if (rdy_s) begin
                        n.st   = ARC_CLOSE; // RQ10
                        n.cnt  = '0;
                        n.rcnt = '0;
                    end else if (r.cnt >= r.set[IDX_CBW]) begin
                        n.st  = ARC_DYNBLK; // RQ13
                        n.cnt = '0;
                    end
                end
                ARC_CLOSE, ARC_RECLAIM: begin
                    if (pick) begin
                        n.cnt = '0;
                        if (last_shot) begin
                            n.st = ARC_DYNBLK; // RQ16
                        end else begin
                            n.shot = r.shot + 2'h1; // RQ11
                            n.st   = trip_s ? ARC_TRIPPED : ARC_ACTION; // RQ14
                        end
                    end else if (r.st == ARC_CLOSE && r.cnt >= r.set[IDX_CLOSE]) begin
                        n.st = ARC_RECLAIM; // RQ14
                    end else if (r.st == ARC_RECLAIM && r.rcnt >= r.set[IDX_RECL]) begin
                        n.st = ARC_IDLE; // RQ12
                    end
                end
                ARC_DYNBLK: begin
                    if (r.cnt >= r.set[IDX_DYN]) begin
                        n.st = ARC_IDLE; // RQ13 RQ23
                    end
                end
                default: n.st = ARC_IDLE;
            endcase
        end
    end

    // Single state register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            r       <= '0;
            r.st    <= ARC_IDLE;
            r.en    <= CTRL_EN_RST;
            r.src   <= CTRL_SRC_RST;
            r.shots <= CTRL_SHOTS_RST;
            r.set   <= {NSET{SET_RST}};
        end else begin
            r <= n;
        end
    end

    // Outputs decode straight from the state register, except avs_waitrequest, which also takes the bus request
    assign avs_readdata    = r.rdata;
    assign avs_waitrequest = (avs_read || avs_write) && !r.ack;
    assign close_out       = (r.st == ARC_CLOSE); // RQ10 RQ23
    assign in_progress_out = (r.st == ARC_TRIPPED) || (r.st == ARC_DTDELAY) || (r.st == ARC_DEAD)
                          || (r.st == ARC_CBWAIT) || (r.st == ARC_CLOSE) || (r.st == ARC_RECLAIM); // RQ5

    // Every check samples on the system clock and rests while reset is low
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    action_expiry_a: assert property ((r.st == ARC_ACTION && !trip_s && !man_s && !inhibit // RQ4
        && r.cnt >= r.set[IDX_ACT]) |=> r.st == ARC_DYNBLK) else $error("action timeout not blocked");
    trip_sets_run_a: assert property ((r.st == ARC_IDLE && trip_s && !inhibit) // RQ5
        |=> in_progress_out) else $error("trip did not set in progress");
    trip_too_long_a: assert property ((r.st == ARC_TRIPPED && !r.src && trip_s && !inhibit // RQ6
        && r.cnt >= r.set[IDX_MAXST]) |=> r.st == ARC_DYNBLK) else $error("long trip not blocked");
    open_missing_a: assert property ((r.st == ARC_TRIPPED && r.src && !popen_s && !inhibit // RQ7
        && r.cnt >= r.set[IDX_MAXST]) |=> r.st == ARC_DYNBLK) else $error("missing open not blocked");
    close_start_a: assert property ((r.st == ARC_CBWAIT && rdy_s && !man_s && !inhibit) // RQ10
        |=> close_out && r.rcnt == 16'h0) else $error("close pulse not issued");
    close_cut_a: assert property ((close_out && trip_s) |=> !close_out) else $error("close not cut by trip"); // RQ14
    tp_sticky_a: assert property ((r.tp && r.st != ARC_IDLE && !inhibit) |=> r.tp) else $error("three-phase lost"); // RQ20
    reduced_dt_a: assert property ((r.st == ARC_DEAD && rdt_s && !man_s && !inhibit) // RQ21
        |=> r.st == ARC_CBWAIT) else $error("reduced dead time ignored");
    dyn_quiet_a: assert property ((r.st == ARC_DYNBLK) |-> !in_progress_out && !close_out) // RQ23
        else $error("outputs active while blocked");
    off_idle_a: assert property ((!r.en && r.st != ARC_DYNBLK) |=> r.st == ARC_IDLE) // RQ17
        else $error("sequence runs while off");
    wait_one_a: assert property ((avs_read && avs_waitrequest) |=> !avs_waitrequest) else $error("bus stall too long");

    // Timed exits and the delay release when nothing else intervenes, plus the manual-close hold
    dyn_release_a: assert property ((r.st == ARC_DYNBLK && r.cnt >= r.set[IDX_DYN]) |=> r.st == ARC_IDLE) // RQ13
        else $error("dynamic block not released");
    delay_skip_a: assert property ((r.st == ARC_DTDELAY && !dtdel_s && !man_s && !inhibit) |=> r.st == ARC_DEAD) // RQ9
        else $error("delay hold not released");
    reclaim_end_a: assert property ((r.st == ARC_RECLAIM && !pick && !man_s && !inhibit // RQ12
        && r.rcnt >= r.set[IDX_RECL]) |=> r.st == ARC_IDLE) else $error("reclaim did not reset");
    pulse_end_a: assert property ((close_out && !pick && !man_s && !inhibit // RQ14
        && r.cnt >= r.set[IDX_CLOSE]) |=> !close_out) else $error("close pulse too long");
    manual_hold_a: assert property (man_s |=> r.mblk) // RQ15
        else $error("manual close not blocking");

    // Covers for the main sequence paths
    close_seen_c: cover property (r.st == ARC_CBWAIT ##1 close_out);
    second_shot_c: cover property (r.st == ARC_RECLAIM && r.shot == 2'h0 ##1 r.shot == 2'h1);
    reclaim_ok_c: cover property (r.st == ARC_RECLAIM ##1 r.st == ARC_IDLE);
    dyn_block_c: cover property (r.st == ARC_CBWAIT ##1 r.st == ARC_DYNBLK);
    delay_seen_c: cover property (r.st == ARC_DTDELAY ##1 r.st == ARC_DEAD);
endmodule : arc_seq
`default_nettype wire

// ==== design/arc_sync.sv ====
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module arc_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_sys,  // System clock
    input  wire logic         reset_n,  // Async reset, active low
    input  wire logic [W-1:0] din,      // Raw inputs from outside
    output logic      [W-1:0] dout      // Filtered synchronous inputs
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] o;
    } arc_sync_t;

    arc_sync_t r, n;

    // First stage feeds only the second; a change counts once stages two and three agree
    always_comb begin
        n    = r;
        n.s1 = din;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.o  = (r.s2 & ~(r.s2 ^ r.s3)) | (r.o & (r.s2 ^ r.s3));
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign dout = r.o;
endmodule : arc_sync
`default_nettype wire

// ==== design/arc_tick.sv ====
// Millisecond tick generator for the sequencer timers
`timescale 1ns/1ps
`default_nettype none
module arc_tick import arc_pkg::*; #(
    parameter int unsigned TICK_CYCLES = TICK_CYC_DEF
) (
    input  wire logic clk_sys,  // System clock
    input  wire logic reset_n,  // Async reset, active low
    output logic      tick      // One-cycle pulse each millisecond
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } arc_tick_t;

    arc_tick_t r, n;

    // Free-running divider; a period of one cycle still ticks each cycle
    always_comb begin
        n = r;
        n.tick = (r.cnt >= 32'(TICK_CYCLES - 1));
        n.cnt  = n.tick ? 32'h0 : r.cnt + 32'h1;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick = r.tick;
endmodule : arc_tick
`default_nettype wire

// ==== verification/arc_far_model.sv ====
// Far-side model: protection trip logic and breaker auxiliary contacts
`timescale 1ns/1ps
`default_nettype none
module arc_far_model (
    input  wire logic        clk_sys,              // System clock
    input  wire logic        reset_n,              // Async reset, active low
    input  wire logic        fault_go,             // One-cycle fault request
    input  wire logic [15:0] trip_len,             // Trip length in clocks
    input  wire logic        ready_hold,           // Breaker not charged
    input  wire logic        close_out,            // Close command in
    output logic             trip_start_in,        // Protection trip
    output logic             breaker_pole_open_in, // Any pole open
    output logic             breaker_ready_in      // Breaker can close
);
    logic [15:0] cnt_q;
    // Trip stands for trip_len clocks; poles open with the trip and stay open until closed
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 16'h0000;
            breaker_pole_open_in <= 1'b0;
        end else begin
            if (fault_go) cnt_q <= trip_len;
            else if (cnt_q != 16'h0000) cnt_q <= cnt_q - 16'h0001;
            if (fault_go) breaker_pole_open_in <= 1'b1;
            else if (close_out) breaker_pole_open_in <= 1'b0;
        end
    end
    assign trip_start_in = (cnt_q != 16'h0000);
    // Slow breaker simply withholds ready while the bench asks
    assign breaker_ready_in = !ready_hold;
endmodule : arc_far_model
`default_nettype wire

// ==== verification/arc_seq_tb.sv ====
// Self-checking testbench for the auto-reclose sequencer
`timescale 1ns/1ps
`default_nettype none
module arc_seq_tb import arc_pkg::*;;
    logic clk_sys, reset_n, avs_read, avs_write, avs_waitrequest, fault_go;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [15:0] trip_len;
    logic block_in, general_block_in, pst, man, dtdel, tph, rdt;
    logic trip, popen, rdy, in_progress_out, close_out;
    int   n_mismatch, num_checks, waited;

    arc_seq #(.TICK_CYCLES(4)) u_arc_seq (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .protection_start_in(pst),
        .trip_start_in(trip), .breaker_pole_open_in(popen), .breaker_ready_in(rdy), .block_in(block_in),
        .general_block_in(general_block_in), .manual_close_in(man), .dead_time_delay_in(dtdel),
        .three_phase_trip_in(tph), .reduced_dead_time_in(rdt), .in_progress_out(in_progress_out),
        .close_out(close_out));
    arc_far_model u_arc_far_model (.clk_sys(clk_sys), .reset_n(reset_n), .fault_go(fault_go),
        .trip_len(trip_len), .ready_hold(1'b0), .close_out(close_out), .trip_start_in(trip),
        .breaker_pole_open_in(popen), .breaker_ready_in(rdy));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task report_and_stop;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One Avalon access; the request holds until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic w;
        int   n;
        n = 0;
        @(posedge clk_sys);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(negedge clk_sys);
            w = avs_waitrequest;
            rd = avs_readdata;
            @(posedge clk_sys);
            n++;
        end while (w !== 1'b0 && n < 20);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (w !== 1'b0) begin
            n_mismatch++;
            $display("MISMATCH t=%0t wait=%h exp=0", $time, w);
            report_and_stop();
        end
    endtask : bus

    // Waits at falling edges, where outputs are settled, for in_progress (sel 0) or close (sel 1)
    task automatic wait_out(input logic sel, input logic v, input int lim);
        waited = 0;
        do begin
            @(negedge clk_sys);
            waited++;
        end while (((sel ? close_out : in_progress_out) !== v) && waited < lim);
        if (waited >= lim) begin
            n_mismatch++;
            $display("MISMATCH t=%0t wait sel=%h v=%h", $time, sel, v);
            report_and_stop();
        end
    endtask : wait_out

    task automatic fault(input logic [15:0] len);
        @(posedge clk_sys);
        trip_len <= len;
        fault_go <= 1'b1;
        @(posedge clk_sys);
        fault_go <= 1'b0;
    endtask : fault

    task sc_regs;
        bus(0, ADDR_CTRL, 0); chk(rd, 32'h4);
        bus(0, 8'h40, 0); chk(rd, 32'h64);
        bus(0, 8'h08, 0); chk(rd, 32'h0);
        bus(1, ADDR_STAT, 32'hffff); bus(0, ADDR_STAT, 0); chk(rd, 32'h0);
        bus(1, 8'h44, 32'd10); bus(1, 8'h48, 32'd5); bus(1, 8'h54, 32'd3);
        bus(1, 8'h60, 32'd5); bus(1, 8'h50, 32'd20);
        bus(0, 8'h60, 0); chk(rd, 32'h5);
        bus(1, ADDR_CTRL, 32'h5);
    endtask : sc_regs

    // Trip, trip reset, dead time, close, reclaim; a second three-phase fault, reduced dead time, restarts at shot one
    task sc_cycle;
        int n;
        fault(16'd20);
        wait_out(0, 1'b1, 20);
        wait_out(1, 1'b1, 200);
        chk(waited >= 40 && waited <= 43, 1);
        n = 0;
        while (close_out === 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        chk(n >= 10 && n <= 13, 1);
        wait_out(0, 1'b0, 80);
        fault(16'd20);
        tph <= 1'b1;
        rdt <= 1'b1;
        wait_out(0, 1'b1, 20);
        bus(0, ADDR_STAT, 0); chk(rd[6:4], 3'h4);
        wait_out(1, 1'b1, 200); chk(waited <= 24, 1);
        wait_out(0, 1'b0, 120);
    endtask : sc_cycle

    // Trip held past the start maximum ends in dynamic block, then idle
    task sc_long;
        fault(16'd70);
        wait_out(0, 1'b1, 20);
        wait_out(0, 1'b0, 80);
        bus(0, ADDR_STAT, 0); chk({rd[2], rd[1]}, 2'h2);
        repeat (140) @(posedge clk_sys);
        bus(0, ADDR_STAT, 0); chk(rd[11:8], 4'h0);
    endtask : sc_long

    // Off, block and general block each keep a trip from starting a sequence
    task sc_blocked;
        logic seen;
        for (int i = 0; i < 3; i++) begin
            bus(1, ADDR_CTRL, (i == 0) ? 32'h4 : 32'h5);
            block_in <= (i == 1);
            general_block_in <= (i == 2);
            repeat (8) @(posedge clk_sys);
            fault(16'd20);
            seen = 1'b0;
            repeat (60) @(negedge clk_sys) if (in_progress_out !== 1'b0) seen = 1'b1;
            chk(seen, 1'b0);
        end
    endtask : sc_blocked

    initial begin
        {avs_read, avs_write, fault_go, block_in, general_block_in, pst, man, dtdel, tph, rdt} = '0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        trip_len = 16'h0000;
        n_mismatch = 0;
        num_checks = 0;
        reset_n = 1'b0;
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        sc_regs();
        sc_cycle();
        sc_long();
        sc_blocked();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        report_and_stop();
    end
endmodule : arc_seq_tb
`default_nettype wire
